// ### design/apsd_pkg.sv
// Constants, register map and carrier types of the front-end path select decoder.
// Assumes a 100 MHz system clock and an APB master with 32-bit data.
// Notes on behaviour
// - Four-bit positive input code closes one path; 0 to 14 valid, 15 none.
// - Three-bit negative input code; 0 is signal ground, 1 to 7 further sources.
// - Two-bit reference-high code: converter reference, divided, millivolt, auxiliary three.
// - Reference-low codes 0 and 6 both analog ground; 1 to 5 distinct; 7 none.
// - Comparator positive code picks one of sixteen sources, thresholds and references included.
// - Register bits let each converter input bypass the RC pre-filter.
// - Without capacitance or continuity, negative threshold follows the two-bit field.
// - Continuity without capacitance forces the short-test threshold.
// - Capacitance picks set one or two by range bit, charge or discharge by comparator.
// - Clearing the buffer enable turns the AC buffer off with high-impedance output.
// - Gain bit zero gives unity gain, one gives external resistor gain.
// - Bypass bit one routes the source to the direct AC pin.
// - Diode bit zero uses the internal diode, one the external diode.
// - Rectifier amplifier is powered only while its enable bit is high.
// - Comparator enable comes straight from its own control bit.
// - Hysteresis bit zero gives none, one gives about 0.1 V hysteresis.
// - Comparator drives counter and charge toggle, inverted pin, readable status bit.
// - Mode 0011 closes the direct-output switch for very fast signals.
// - Two results: slow high-resolution with the offset chopped out, fast low-resolution with offset.
// - Modulator bit stream is averaged into a multi-bit result by a digital filter.
// - Modes 101x set capacitance, 100x continuity, 0001 only the diode flag.
package apsd_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int SAMPLE_HZ = 166_700;
    localparam int SAMPLE_DIV = CLK_HZ / SAMPLE_HZ;
    localparam int HI_TAPS = 16384;
    localparam int LO_TAPS = 256;
    localparam int ACC_W = 16;

    localparam logic [7:0] OFS_PATH = 8'h00;
    localparam logic [7:0] OFS_CTRL = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_HIRES = 8'h0C;
    localparam logic [7:0] OFS_LORES = 8'h10;

    localparam logic [3:0] MODE_DIODE = 4'h1;
    localparam logic [3:0] MODE_HBW = 4'h3;
    localparam logic [2:0] MODE_CONT_TOP = 3'h4;
    localparam logic [2:0] MODE_CAP_TOP = 3'h5;
    localparam logic [3:0] POS_NONE = 4'hF;
    localparam logic [2:0] REFL_ANALOG_GROUND_ALT = 3'h6;
    localparam logic [2:0] REFL_NONE = 3'h7;

    localparam int TH_ANALOG_GROUND = 0;
    localparam int TH_SPARE = 1;
    localparam int TH_CHG2 = 2;
    localparam int TH_OHM = 3;
    localparam int TH_SHORT = 4;
    localparam int TH_CHG1 = 5;
    localparam int TH_DIS1 = 6;
    localparam int TH_DIS2 = 7;

    typedef struct packed {
        logic prefilter_bypass_neg;
        logic prefilter_bypass_pos;
        logic capacitance_range_bit;
        logic [1:0] comparator_threshold_select;
        logic [3:0] comparator_pos_select;
        logic [2:0] ref_low_select;
        logic [1:0] ref_high_select;
        logic [2:0] neg_input_select;
        logic [3:0] pos_input_select;
    } apsd_path_s;

    typedef struct packed {
        logic hysteresis_select_bit;
        logic comparator_enable_bit;
        logic rectifier_enable;
        logic diode_select_bit;
        logic buffer_bypass_bit;
        logic buffer_gain_bit;
        logic ac_buffer_enable;
        logic [3:0] measurement_mode_field;
    } apsd_ctrl_s;

    typedef struct packed {
        logic [14:0] pos_converter_mux;
        logic [7:0] neg_converter_mux;
        logic [3:0] ref_high_mux;
        logic [5:0] ref_low_mux;
        logic [15:0] comparator_pos_mux;
        logic [7:0] comparator_neg_threshold;
        logic prefilter_bypass_pos;
        logic prefilter_bypass_neg;
        logic ac_buffer_enable;
        logic ac_buffer_hiz;
        logic buffer_gain_bit;
        logic buffer_bypass_bit;
        logic diode_select_bit;
        logic rectifier_enable;
        logic comparator_enable_bit;
        logic hysteresis_select_bit;
        logic direct_output_switch;
        logic fixed_source_enable;
    } apsd_sw_s;

    localparam apsd_path_s PATH_RST = '0;
    localparam apsd_ctrl_s CTRL_RST = '0;
endpackage

// ### design/apsd_comb.sv
// Averaging filter for the one-bit modulator stream.
// Assumes sample_en is a one-cycle pulse at the modulator rate.
`timescale 1ns/1ps
module apsd_comb #(
    parameter int TAPS = 256
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic sample_en,
    input wire logic bit_in,
    output logic signed [apsd_pkg::ACC_W:0] result,
    output logic done
);
    import apsd_pkg::*;

    localparam logic [ACC_W-1:0] LAST = ACC_W'(TAPS - 1);
    localparam logic signed [ACC_W:0] HALF = (ACC_W+1)'(TAPS);

    logic [ACC_W-1:0] count_ff;
    logic [ACC_W:0] ones_ff;
    logic signed [ACC_W:0] result_ff;
    logic done_ff;
    logic [ACC_W:0] ones_now;

    assign ones_now = ones_ff + {{ACC_W{1'b0}}, bit_in};

    // Count of ones over a window gives the average of the stream
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            count_ff <= '0;
            ones_ff <= '0;
        end else if (sample_en) begin
            if (count_ff == LAST) begin
                count_ff <= '0;
                ones_ff <= '0;
            end else begin
                count_ff <= count_ff + 1'b1;
                ones_ff <= ones_now;
            end
        end
    end

    // Bipolar result: twice the ones minus the window length
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            result_ff <= '0;
            done_ff <= 1'b0;
        end else begin
            done_ff <= sample_en && (count_ff == LAST);
            if (sample_en && (count_ff == LAST)) begin
                result_ff <= signed'({ones_now[ACC_W-1:0], 1'b0}) - HALF;
            end
        end
    end

    assign result = result_ff;
    assign done = done_ff;
endmodule // apsd_comb

// ### design/apsd_top.sv
// Path select and enable decoder of the meter front end, with APB registers
// and the two converter result filters.
// Assumes APB in the clock domain and a comparator and modulator bit already
// synchronous to the clock.
`timescale 1ns/1ps
module apsd_top #(
    parameter int HI_TAPS = apsd_pkg::HI_TAPS,
    parameter int SAMPLE_DIV = apsd_pkg::SAMPLE_DIV
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic comparator_in,
    input wire logic modulator_bit,
    output apsd_pkg::apsd_sw_s switches,
    output logic freq_counter_input,
    output logic charge_toggle,
    output logic comparator_n_pin,
    output logic chop
);
    import apsd_pkg::*;

    localparam int PATH_W = $bits(apsd_path_s);
    localparam int CTRL_W = $bits(apsd_ctrl_s);
    localparam int DIV_W = 16;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SAMPLE_DIV - 1);

    apsd_path_s path_ff;
    apsd_ctrl_s ctrl_ff;
    apsd_sw_s sw_ff;
    apsd_sw_s nxt_sw;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    logic pready_ff;
    logic pslverr_ff;
    logic nxt_err;
    logic cmp_ff;
    logic cmp_n_ff;
    logic chop_ff;
    logic [DIV_W-1:0] div_ff;
    logic sample_en_ff;
    logic hi_new_ff;
    logic lo_new_ff;
    logic signed [ACC_W:0] hi_first_ff;
    logic signed [ACC_W:0] hires_ff;
    logic signed [ACC_W:0] lores_ff;
    logic signed [ACC_W:0] hi_sum;
    logic signed [ACC_W:0] lo_sum;
    logic signed [ACC_W+1:0] hi_diff;
    logic hi_done;
    logic lo_done;
    logic wr_en;
    logic rd_en;
    logic access;
    logic cap_flag;
    logic cont_flag;
    logic diode_flag;
    logic src_flag;

    assign access = psel && penable && pready_ff;
    assign wr_en = access && pwrite;
    assign rd_en = access && !pwrite;

    // Mode flags
    always_comb begin
        cap_flag = (ctrl_ff.measurement_mode_field[3:1] == MODE_CAP_TOP);
        cont_flag = (ctrl_ff.measurement_mode_field[3:1] == MODE_CONT_TOP);
        diode_flag = (ctrl_ff.measurement_mode_field == MODE_DIODE);
        src_flag = cap_flag || cont_flag || (ctrl_ff.measurement_mode_field == MODE_HBW);
    end

    // Bus answer one cycle into the access phase, so every answer comes from a flop
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= '0;
        end else begin
            pready_ff <= psel && penable && !pready_ff;
            pslverr_ff <= psel && penable && !pready_ff && nxt_err;
            if (psel && penable && !pready_ff) begin
                prdata_ff <= pwrite ? 32'h0000_0000 : nxt_prdata;
            end
        end
    end

    // Read mux and unmapped decode
    always_comb begin
        nxt_prdata = 32'h0000_0000;
        nxt_err = 1'b0;
        if (paddr == OFS_PATH) begin
            nxt_prdata[PATH_W-1:0] = path_ff;
        end else if (paddr == OFS_CTRL) begin
            nxt_prdata[CTRL_W-1:0] = ctrl_ff;
        end else if (paddr == OFS_STATUS) begin
            nxt_prdata[0] = cmp_ff;
            nxt_prdata[1] = cap_flag;
            nxt_prdata[2] = cont_flag;
            nxt_prdata[3] = diode_flag;
            nxt_prdata[4] = hi_new_ff;
            nxt_prdata[5] = lo_new_ff;
            nxt_prdata[6] = chop_ff;
        end else if (paddr == OFS_HIRES) begin
            nxt_prdata = {{(31-ACC_W){hires_ff[ACC_W]}}, hires_ff};
        end else if (paddr == OFS_LORES) begin
            nxt_prdata = {{(31-ACC_W){lores_ff[ACC_W]}}, lores_ff};
        end else begin
            nxt_err = 1'b1;
        end
    end

    // Path select register
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            path_ff <= PATH_RST;
        end else if (wr_en && (paddr == OFS_PATH)) begin
            path_ff <= pwdata[PATH_W-1:0];
        end
    end

    // Control register
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ctrl_ff <= CTRL_RST;
        end else if (wr_en && (paddr == OFS_CTRL)) begin
            ctrl_ff <= pwdata[CTRL_W-1:0];
        end
    end

    // Comparator copies
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cmp_ff <= 1'b0;
            cmp_n_ff <= 1'b1;
        end else begin
            cmp_ff <= comparator_in;
            cmp_n_ff <= !comparator_in;
        end
    end

    // Switch decode
    always_comb begin
        nxt_sw = '0;
        if (path_ff.pos_input_select != POS_NONE) begin
            nxt_sw.pos_converter_mux = 15'h0001 << path_ff.pos_input_select;
        end
        nxt_sw.neg_converter_mux = 8'h01 << path_ff.neg_input_select;
        nxt_sw.ref_high_mux = 4'h1 << path_ff.ref_high_select;
        if (path_ff.ref_low_select == REFL_ANALOG_GROUND_ALT) begin
            nxt_sw.ref_low_mux = 6'h01;
        end else if (path_ff.ref_low_select != REFL_NONE) begin
            nxt_sw.ref_low_mux = 6'h01 << path_ff.ref_low_select;
        end
        nxt_sw.comparator_pos_mux = 16'h0001 << path_ff.comparator_pos_select;
        // Threshold priority: capacitance, then continuity, then field
        if (cap_flag) begin
            if (path_ff.capacitance_range_bit) begin
                nxt_sw.comparator_neg_threshold[cmp_ff ? TH_DIS2 : TH_CHG2] = 1'b1;
            end else begin
                nxt_sw.comparator_neg_threshold[cmp_ff ? TH_DIS1 : TH_CHG1] = 1'b1;
            end
        end else if (cont_flag) begin
            nxt_sw.comparator_neg_threshold[TH_SHORT] = 1'b1;
        end else begin
            case (path_ff.comparator_threshold_select)
                2'h0: nxt_sw.comparator_neg_threshold[TH_ANALOG_GROUND] = 1'b1;
                2'h1: nxt_sw.comparator_neg_threshold[TH_SPARE] = 1'b1;
                2'h2: nxt_sw.comparator_neg_threshold[TH_CHG2] = 1'b1;
                default: nxt_sw.comparator_neg_threshold[TH_OHM] = 1'b1;
            endcase
        end
        nxt_sw.prefilter_bypass_pos = path_ff.prefilter_bypass_pos;
        nxt_sw.prefilter_bypass_neg = path_ff.prefilter_bypass_neg;
        nxt_sw.ac_buffer_enable = ctrl_ff.ac_buffer_enable;
        nxt_sw.ac_buffer_hiz = !ctrl_ff.ac_buffer_enable;
        nxt_sw.buffer_gain_bit = ctrl_ff.buffer_gain_bit;
        nxt_sw.buffer_bypass_bit = ctrl_ff.buffer_bypass_bit;
        nxt_sw.diode_select_bit = ctrl_ff.diode_select_bit;
        nxt_sw.rectifier_enable = ctrl_ff.rectifier_enable;
        nxt_sw.comparator_enable_bit = ctrl_ff.comparator_enable_bit;
        nxt_sw.hysteresis_select_bit = ctrl_ff.hysteresis_select_bit;
        nxt_sw.direct_output_switch = (ctrl_ff.measurement_mode_field == MODE_HBW);
        nxt_sw.fixed_source_enable = src_flag;
    end

    // Registered switch drive keeps decode glitches off the analog switches
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sw_ff <= '0;
        end else begin
            sw_ff <= nxt_sw;
        end
    end

    // Modulator sample rate divider
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            div_ff <= '0;
            sample_en_ff <= 1'b0;
        end else begin
            sample_en_ff <= (div_ff == DIV_LAST);
            div_ff <= (div_ff == DIV_LAST) ? '0 : div_ff + 1'b1;
        end
    end

    apsd_comb #(
        .TAPS(HI_TAPS)
    ) u_hi_comb (
        .clock(clock),
        .rstn(rstn),
        .sample_en(sample_en_ff),
        .bit_in(modulator_bit ^ chop_ff),
        .result(hi_sum),
        .done(hi_done)
    );

    apsd_comb #(
        .TAPS(LO_TAPS)
    ) u_lo_comb (
        .clock(clock),
        .rstn(rstn),
        .sample_en(sample_en_ff),
        .bit_in(modulator_bit),
        .result(lo_sum),
        .done(lo_done)
    );

    // Chopped window pair: the signal flips sign in the inverted second half and the offset does not, so the difference cancels it.
    // Costs half the output rate of the slow path.
    assign hi_diff = {hi_first_ff[ACC_W], hi_first_ff} - {hi_sum[ACC_W], hi_sum};

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            chop_ff <= 1'b0;
            hi_first_ff <= '0;
            hires_ff <= '0;
        end else if (hi_done) begin
            chop_ff <= !chop_ff;
            if (!chop_ff) begin
                hi_first_ff <= hi_sum;
            end else begin
                hires_ff <= hi_diff[ACC_W+1:1];
            end
        end
    end

    // Fast path keeps the offset
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            lores_ff <= '0;
        end else if (lo_done) begin
            lores_ff <= lo_sum;
        end
    end

    // New-result flags; a fresh result beats the clear by read
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            hi_new_ff <= 1'b0;
            lo_new_ff <= 1'b0;
        end else begin
            if (hi_done && chop_ff) begin
                hi_new_ff <= 1'b1;
            end else if (rd_en && (paddr == OFS_HIRES)) begin
                hi_new_ff <= 1'b0;
            end
            if (lo_done) begin
                lo_new_ff <= 1'b1;
            end else if (rd_en && (paddr == OFS_LORES)) begin
                lo_new_ff <= 1'b0;
            end
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign switches = sw_ff;
    assign freq_counter_input = cmp_ff;
    assign charge_toggle = cmp_ff;
    assign comparator_n_pin = cmp_n_ff;
    assign chop = chop_ff;
endmodule // apsd_top

// ### dv/apsd_checker.sv
// Concurrent checks on the ports of the path select decoder top.
// Assumes one clock domain with an active-low asynchronous reset.
`timescale 1ns/1ps
module apsd_checker #(
    parameter int HI_TAPS = 16,
    parameter int SAMPLE_DIV = 2
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic comparator_in,
    input wire apsd_pkg::apsd_sw_s switches,
    input wire logic freq_counter_input,
    input wire logic charge_toggle,
    input wire logic comparator_n_pin
);
    import apsd_pkg::*;
    logic live_ff, wr_ctrl_ff, wr_hbw_ff, cap1;
    logic [6:0] en_bits;
    assign cap1 = switches.comparator_neg_threshold[TH_CHG1] | switches.comparator_neg_threshold[TH_DIS1];
    assign en_bits = {switches.ac_buffer_enable, switches.buffer_gain_bit, switches.buffer_bypass_bit,
        switches.diode_select_bit, switches.rectifier_enable, switches.comparator_enable_bit,
        switches.hysteresis_select_bit};
    // Switch outputs only carry a decode from the first edge after release
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            live_ff <= 1'b0;
            wr_ctrl_ff <= 1'b0;
            wr_hbw_ff <= 1'b0;
        end else begin
            live_ff <= 1'b1;
            wr_ctrl_ff <= psel & penable & pready & pwrite & (paddr == OFS_CTRL);
            wr_hbw_ff <= psel & penable & pready & pwrite & (paddr == OFS_CTRL) & (pwdata[3:0] == MODE_HBW);
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    AST_POS: assert property (live_ff |-> $onehot0(switches.pos_converter_mux))
        else $error("positive mux closes several paths");
    AST_NEG: assert property (live_ff |-> $onehot(switches.neg_converter_mux))
        else $error("negative mux not one-hot");
    AST_REFH: assert property (live_ff |-> $onehot(switches.ref_high_mux))
        else $error("reference high mux not one-hot");
    AST_REFL: assert property (live_ff |-> $onehot0(switches.ref_low_mux))
        else $error("reference low mux closes several paths");
    AST_CMPP: assert property (live_ff |-> $onehot(switches.comparator_pos_mux))
        else $error("comparator positive mux not one-hot");
    AST_THR: assert property (live_ff |-> $onehot(switches.comparator_neg_threshold))
        else $error("threshold select not one-hot");
    AST_CAP1: assert property (cap1 && $past(cap1) |->
        switches.comparator_neg_threshold[TH_DIS1] == $past(comparator_in, 2))
        else $error("charge threshold does not follow comparator");
    AST_HIZ: assert property (live_ff |-> switches.ac_buffer_hiz != switches.ac_buffer_enable)
        else $error("buffer high impedance disagrees with enable");
    AST_CTRL_LAT: assert property ($changed(en_bits) |-> $past(wr_ctrl_ff))
        else $error("enable bits changed without control write");
    AST_DVO: assert property ($rose(switches.direct_output_switch) |-> $past(wr_hbw_ff))
        else $error("direct output closed without mode write");
    AST_CMP_OUT: assert property (live_ff |-> freq_counter_input == $past(comparator_in) &&
        charge_toggle == freq_counter_input && comparator_n_pin != freq_counter_input)
        else $error("comparator copies disagree");
    AST_ERR: assert property (pslverr |-> pready && !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10}))
        else $error("error response on a mapped address");
    AST_PREADY: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
endmodule // apsd_checker
bind apsd_top apsd_checker #(.HI_TAPS(HI_TAPS), .SAMPLE_DIV(SAMPLE_DIV)) u_apsd_checker (
    .clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .comparator_in(comparator_in),
    .switches(switches), .freq_counter_input(freq_counter_input), .charge_toggle(charge_toggle),
    .comparator_n_pin(comparator_n_pin));

// ### dv/apsd_analog_model.sv
// Behavioural stand-in for the analog switch network and the modulator.
// Assumes the bench commands the comparator level and the decision bit.
`timescale 1ns/1ps
module apsd_analog_model (
    input wire logic clock,
    input wire logic rstn,
    input wire apsd_pkg::apsd_sw_s switches,
    input wire logic comp_cmd,
    input wire logic mod_cmd,
    output logic comparator_in,
    output logic modulator_bit
);
    import apsd_pkg::*;
    // A disabled comparator rests low so no stale level reaches the counter
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            comparator_in <= 1'b0;
            modulator_bit <= 1'b0;
        end else begin
            comparator_in <= comp_cmd & switches.comparator_enable_bit;
            modulator_bit <= mod_cmd;
        end
    end
endmodule // apsd_analog_model

// ### dv/apsd_tb_top.sv
// Self-checking bench: APB stimulus, analog partner, reference decode model.
// Assumes package, design, checker and partner are compiled first.
`timescale 1ns/1ps
module apsd_tb_top;
    import apsd_pkg::*;
    localparam int HT = 16;
    localparam int LT = 256;
    logic clock, rstn, psel, penable, pwrite, pready, pslverr;
    logic comparator_in, modulator_bit, comp_cmd, mod_cmd;
    logic freq_counter_input, charge_toggle, comparator_n_pin, chop;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    apsd_sw_s switches;
    int n_fail, checks;
    apsd_top #(.HI_TAPS(HT), .SAMPLE_DIV(2)) dut (.clock(clock), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .comparator_in(comparator_in), .modulator_bit(modulator_bit),
        .switches(switches), .freq_counter_input(freq_counter_input), .charge_toggle(charge_toggle),
        .comparator_n_pin(comparator_n_pin), .chop(chop));
    apsd_analog_model u_ana (.clock(clock), .rstn(rstn), .switches(switches), .comp_cmd(comp_cmd),
        .mod_cmd(mod_cmd), .comparator_in(comparator_in), .modulator_bit(modulator_bit));
    task automatic cmp_w(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic cmp_sw(input apsd_sw_s e);
        checks++;
        if (switches !== e) begin
            n_fail++;
            $display("[FAIL] switches exp %h got %h", e, switches);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        cmp_w("pready", 32'h1, {31'h0, pready});
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, 32'h0, rd, err);
        cmp_w(nm, e & m, rd & m);
        cmp_w("pslverr", 32'h0, {31'h0, err});
    endtask
    function automatic apsd_sw_s model(input logic [31:0] p, input logic [31:0] c, input logic k);
        apsd_sw_s s;
        logic cap, cont;
        int th;
        s = '0;
        cap = c[3:1] == 3'b101;
        cont = c[3:1] == 3'b100;
        if (p[3:0] != 4'hF) s.pos_converter_mux[p[3:0]] = 1'b1;
        s.neg_converter_mux[p[6:4]] = 1'b1;
        s.ref_high_mux[p[8:7]] = 1'b1;
        if (p[11:9] == 3'h6) s.ref_low_mux[0] = 1'b1;
        else if (p[11:9] != 3'h7) s.ref_low_mux[p[11:9]] = 1'b1;
        s.comparator_pos_mux[p[15:12]] = 1'b1;
        th = cap ? (p[18] ? (k ? TH_DIS2 : TH_CHG2) : (k ? TH_DIS1 : TH_CHG1)) : cont ? TH_SHORT : int'(p[17:16]);
        s.comparator_neg_threshold[th] = 1'b1;
        {s.prefilter_bypass_neg, s.prefilter_bypass_pos} = p[20:19];
        {s.hysteresis_select_bit, s.comparator_enable_bit, s.rectifier_enable, s.diode_select_bit} = c[10:7];
        {s.buffer_bypass_bit, s.buffer_gain_bit, s.ac_buffer_enable} = c[6:4];
        s.ac_buffer_hiz = !c[4];
        s.direct_output_switch = c[3:0] == 4'h3;
        s.fixed_source_enable = cap | cont | s.direct_output_switch;
        return s;
    endfunction
    task automatic apply(input logic [31:0] p, input logic [31:0] c, input logic k);
        logic [31:0] rd;
        logic err, ke;
        ke = k & c[9];
        comp_cmd <= k;
        apb(1'b1, OFS_PATH, p, rd, err);
        apb(1'b1, OFS_CTRL, c, rd, err);
        // Covers the switch latency and the comparator feedback delay
        repeat (4) @(posedge clock);
        cmp_sw(model(p, c, ke));
        cmp_w("cmp_out", {29'h0, ke, ke, !ke}, {29'h0, freq_counter_input, charge_toggle, comparator_n_pin});
        rdc("status", OFS_STATUS, 32'hF, {28'h0, c[3:0] == MODE_DIODE, c[3:1] == 3'b100, c[3:1] == 3'b101, ke});
        rdc("path", OFS_PATH, 32'h1FFFFF, p);
        rdc("ctrl", OFS_CTRL, 32'h7FF, c);
    endtask
    task automatic waitflag(input int bn);
        logic [31:0] rd;
        logic err;
        int n;
        n = 0;
        do begin
            apb(1'b0, OFS_STATUS, 32'h0, rd, err);
            n++;
        end while (rd[bn] !== 1'b1 && n < 400);
        cmp_w("result flag", 32'h1, {31'h0, rd[bn]});
    endtask
    task automatic print_verdict();
        if (n_fail == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial begin
        #200_000;
        n_fail++;
        print_verdict();
    end
    initial begin
        logic [31:0] rd, p, c;
        logic [3:0] i;
        logic err;
        int v;
        rstn = 1'b0;
        {psel, penable, pwrite, comp_cmd} = 4'h0;
        mod_cmd = 1'b1;
        paddr = 8'h00;
        pwdata = 32'h0;
        n_fail = 0;
        checks = 0;
        v = $urandom(32'h68302270);
        repeat (4) @(posedge clock);
        rstn <= 1'b1;
        repeat (2) @(posedge clock);
        cmp_sw(model(32'h0, 32'h0, 1'b0));
        rdc("path", OFS_PATH, 32'hFFFFFFFF, 32'h0);
        rdc("ctrl", OFS_CTRL, 32'hFFFFFFFF, 32'h0);
        for (int j = 0; j < 32; j++) begin
            i = j[3:0];
            p = {11'h0, i[1], i[0], j[4], i[1:0], i, i[2:0], i[1:0], i[2:0], i};
            c = {21'h0, i[0], i[1], i[2], i[3], j[4], i[0], !i[0], i};
            apply(p, c, j[4] ^ i[0]);
        end
        repeat (30) begin
            p = $urandom & 32'h1FFFFF;
            c = $urandom & 32'h7FF;
            v = $urandom;
            apply(p, c, v[0]);
        end
        apb(1'b1, OFS_STATUS, 32'hFFFFFFFF, rd, err);
        cmp_w("pslverr", 32'h0, {31'h0, err});
        apb(1'b1, 8'h14, 32'hFFFFFFFF, rd, err);
        cmp_w("pslverr", 32'h1, {31'h0, err});
        apb(1'b0, 8'h14, 32'h0, rd, err);
        cmp_w("pslverr", 32'h1, {31'h0, err});
        cmp_w("prdata", 32'h0, rd);
        rdc("path", OFS_PATH, 32'h1FFFFF, p);
        for (int b = 1; b >= 0; b--) begin
            mod_cmd <= b[0];
            // First two results may hold windows from before the change
            for (int r = 0; r < 3; r++) begin
                waitflag(5);
                apb(1'b0, OFS_LORES, 32'h0, rd, err);
            end
            v = LT * (2 * b - 1);
            cmp_w("lores", v, rd);
            for (int r = 0; r < 3; r++) begin
                waitflag(4);
                apb(1'b0, OFS_HIRES, 32'h0, rd, err);
            end
            v = HT * (2 * b - 1);
            cmp_w("hires", v, rd);
            // A fresh pair has just ended, so the first half of the next pair runs
            cmp_w("chop", 32'h0, {31'h0, chop});
        end
        print_verdict();
    end
endmodule // apsd_tb_top
